// *** tmr_pkg.sv ***
package tmr_pkg;

	// ------------------------------------------------------------
	// register indices (byte address = index * 4)
	// ------------------------------------------------------------
	localparam logic [5:0] IDX_CTRL_A = 6'h30;
	localparam logic [5:0] IDX_COUNT  = 6'h32;
	localparam logic [5:0] IDX_CTRL_B = 6'h33;
	localparam logic [5:0] IDX_CMP_A  = 6'h36;
	localparam logic [5:0] IDX_FLAGS  = 6'h38;
	localparam logic [5:0] IDX_MASK   = 6'h39;
	localparam logic [5:0] IDX_CMP_B  = 6'h3C;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int FOC_A_BIT   = 7;
	localparam int FOC_B_BIT   = 6;
	localparam int WM2_BIT     = 3;
	localparam int OMA_LSB     = 6;
	localparam int OMB_LSB     = 4;
	localparam int FLG_CMPB    = 2;
	localparam int FLG_CMPA    = 1;
	localparam int FLG_OVF     = 0;

	// ------------------------------------------------------------
	// values after reset and fixed counts
	// ------------------------------------------------------------
	localparam logic [7:0] RST_BYTE   = 8'h00;
	localparam logic [2:0] RST_FLAGS  = 3'h0;
	localparam logic [9:0] RST_PRE    = 10'h000;
	localparam logic [7:0] CNT_MAX    = 8'hFF;
	localparam logic [7:0] CNT_BOTTOM = 8'h00;
	localparam logic [7:0] CNT_ONE    = 8'h01;

	// clock-select codes
	localparam logic [2:0] CS_STOP    = 3'h0;
	localparam logic [2:0] CS_DIV1    = 3'h1;
	localparam logic [2:0] CS_DIV8    = 3'h2;
	localparam logic [2:0] CS_DIV64   = 3'h3;
	localparam logic [2:0] CS_DIV256  = 3'h4;
	localparam logic [2:0] CS_DIV1024 = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;

	// wave-mode codes
	localparam logic [2:0] WM_NORMAL  = 3'h0;
	localparam logic [2:0] WM_PC_FF   = 3'h1;
	localparam logic [2:0] WM_CTC     = 3'h2;
	localparam logic [2:0] WM_FAST_FF = 3'h3;
	localparam logic [2:0] WM_PC_A    = 3'h5;
	localparam logic [2:0] WM_FAST_A  = 3'h7;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** tmr_timer8.sv ***
module tmr_timer8 (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        ext_count_pin,
	input  wire logic        global_irq_enable,
	input  wire logic        ack_overflow,
	input  wire logic        ack_compare_a,
	input  wire logic        ack_compare_b,
	output logic             irq_overflow,
	output logic             irq_compare_a,
	output logic             irq_compare_b,
	output logic             wave_out_a,
	output logic             wave_out_b,
	output logic             wave_oe_a,
	output logic             wave_oe_b
);

	// ------------------------------------------------------------
	// bus slave
	// ------------------------------------------------------------
	logic        aw_full, next_aw_full, w_full, next_w_full;
	logic [5:0]  aw_idx, next_aw_idx;
	logic [7:0]  w_byte, next_w_byte;
	logic        w_lane, next_w_lane;
	logic        next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
	logic [1:0]  next_bresp, next_rresp;
	logic [31:0] next_rdata;
	logic        do_write, do_read, wr_en;
	logic [7:0]  rd_byte;
	logic        rd_hit;

	function automatic logic idx_mapped(input logic [5:0] idx);
		idx_mapped = (idx == tmr_pkg::IDX_CTRL_A) || (idx == tmr_pkg::IDX_CTRL_B) ||
			(idx == tmr_pkg::IDX_COUNT) || (idx == tmr_pkg::IDX_CMP_A) ||
			(idx == tmr_pkg::IDX_CMP_B) || (idx == tmr_pkg::IDX_MASK) ||
			(idx == tmr_pkg::IDX_FLAGS);
	endfunction

	// timer state declared early for the read mux
	logic [7:0] ctrl_a, count, cmp_a, cmp_b;
	logic       wm_bit2;
	logic [2:0] clk_sel, mask, flags;

	always_comb begin
		do_write     = aw_full && w_full && !s_axi_bvalid;
		wr_en        = do_write && w_lane && idx_mapped(aw_idx);
		do_read      = s_axi_arvalid && s_axi_arready;
		next_aw_full = (aw_full && !do_write) || (s_axi_awvalid && s_axi_awready);
		next_w_full  = (w_full && !do_write) || (s_axi_wvalid && s_axi_wready);
		next_aw_idx  = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr[7:2] : aw_idx;
		next_w_byte  = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata[7:0] : w_byte;
		next_w_lane  = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb[0] : w_lane;
		next_awready = !next_aw_full;
		next_wready  = !next_w_full;
		next_bvalid  = do_write || (s_axi_bvalid && !s_axi_bready);
		next_bresp   = do_write ? (idx_mapped(aw_idx) ? tmr_pkg::RESP_OKAY :
			tmr_pkg::RESP_SLVERR) : s_axi_bresp;
		next_rvalid  = do_read || (s_axi_rvalid && !s_axi_rready);
		next_arready = !next_rvalid;
		rd_hit       = 1'b1;
		unique case (s_axi_araddr[7:2])
			tmr_pkg::IDX_CTRL_A: rd_byte = ctrl_a;
			tmr_pkg::IDX_CTRL_B: rd_byte = {4'h0, wm_bit2, clk_sel};
			tmr_pkg::IDX_COUNT:  rd_byte = count;
			tmr_pkg::IDX_CMP_A:  rd_byte = cmp_a;
			tmr_pkg::IDX_CMP_B:  rd_byte = cmp_b;
			tmr_pkg::IDX_MASK:   rd_byte = {5'h00, mask};
			tmr_pkg::IDX_FLAGS:  rd_byte = {5'h00, flags};
			default: begin
				rd_byte = tmr_pkg::RST_BYTE;
				rd_hit  = 1'b0;
			end
		endcase
		next_rdata = do_read ? {24'h000000, rd_byte} : s_axi_rdata;
		next_rresp = do_read ? (rd_hit ? tmr_pkg::RESP_OKAY : tmr_pkg::RESP_SLVERR) :
			s_axi_rresp;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full       <= 1'b0;
			w_full        <= 1'b0;
			aw_idx        <= 6'h00;
			w_byte        <= tmr_pkg::RST_BYTE;
			w_lane        <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= tmr_pkg::RESP_OKAY;
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= tmr_pkg::RESP_OKAY;
		end else begin
			aw_full       <= next_aw_full;
			w_full        <= next_w_full;
			aw_idx        <= next_aw_idx;
			w_byte        <= next_w_byte;
			w_lane        <= next_w_lane;
			s_axi_awready <= next_awready;
			s_axi_wready  <= next_wready;
			s_axi_bvalid  <= next_bvalid;
			s_axi_bresp   <= next_bresp;
			s_axi_arready <= next_arready;
			s_axi_rvalid  <= next_rvalid;
			s_axi_rdata   <= next_rdata;
			s_axi_rresp   <= next_rresp;
		end
	end

	// ------------------------------------------------------------
	// timer core
	// ------------------------------------------------------------
	logic [7:0] next_ctrl_a, next_count, next_cmp_a, next_cmp_b;
	logic       next_wm_bit2, dir_down, next_dir_down, blocked, next_blocked;
	logic [2:0] next_clk_sel, next_mask, next_flags, set_f, clr_f;
	logic [9:0] pre, next_pre;
	logic       pin_s1, pin_s2, pin_prev;
	logic       next_wave_a, next_wave_b;
	logic [2:0] next_irq;
	logic [2:0] wm;
	logic [7:0] top, ovf_pt;
	logic       tick, is_pwm, is_fast, is_phase, hit_a, hit_b, ovf_evt, at_bot;
	logic       force_a, force_b;

	// prescaler taps are all-ones in the low bits, one cycle per period
	function automatic logic tap_hit(input logic [9:0] p, input int bits);
		tap_hit = &(p | ~((10'h001 << bits) - 10'h001));
	endfunction

	function automatic logic wave_step(input logic [1:0] om, input logic cur,
		input logic pwm, input logic fast, input logic hit, input logic bot,
		input logic down, input logic tog_ok);
		logic r;
		r = cur;
		if (!pwm) begin
			if (hit) begin
				unique case (om)
					2'h1: r = !cur;
					2'h2: r = 1'b0;
					2'h3: r = 1'b1;
					2'h0: r = cur;
				endcase
			end
		end else if (om[1]) begin
			if (hit)
				r = fast ? om[0] : (om[0] ^ down);
			if (fast && bot)
				r = !om[0];
		end else if (om[0] && tog_ok && hit) begin
			r = !cur;
		end
		wave_step = r;
	endfunction

	always_comb begin
		wm       = {wm_bit2, ctrl_a[1:0]};
		is_pwm   = wm[0];
		is_fast  = wm[1:0] == 2'h3;
		is_phase = wm[1:0] == 2'h1;
		top      = (wm == tmr_pkg::WM_CTC || wm == tmr_pkg::WM_PC_A ||
			wm == tmr_pkg::WM_FAST_A) ? cmp_a : tmr_pkg::CNT_MAX;
		ovf_pt   = (wm == tmr_pkg::WM_FAST_A) ? top : tmr_pkg::CNT_MAX;
		unique case (clk_sel)
			tmr_pkg::CS_STOP:     tick = 1'b0;
			tmr_pkg::CS_DIV1:     tick = 1'b1;
			tmr_pkg::CS_DIV8:     tick = tap_hit(pre, 3);
			tmr_pkg::CS_DIV64:    tick = tap_hit(pre, 6);
			tmr_pkg::CS_DIV256:   tick = tap_hit(pre, 8);
			tmr_pkg::CS_DIV1024:  tick = tap_hit(pre, 10);
			tmr_pkg::CS_EXT_FALL: tick = pin_prev && !pin_s2;
			tmr_pkg::CS_EXT_RISE: tick = !pin_prev && pin_s2;
		endcase
		// a write to the counter removes the match on the next tick
		hit_a   = tick && !blocked && (count == cmp_a);
		hit_b   = tick && !blocked && (count == cmp_b);
		at_bot  = tick && !is_phase && (count == top);
		ovf_evt = tick && (is_phase ? (dir_down && count == tmr_pkg::CNT_ONE) :
			(count == ovf_pt));
		force_a = wr_en && aw_idx == tmr_pkg::IDX_CTRL_B &&
			w_byte[tmr_pkg::FOC_A_BIT] && !is_pwm;
		force_b = wr_en && aw_idx == tmr_pkg::IDX_CTRL_B &&
			w_byte[tmr_pkg::FOC_B_BIT] && !is_pwm;

		next_pre      = pre + 10'h001;
		next_dir_down = dir_down;
		next_count    = count;
		next_blocked  = blocked && !tick;
		if (tick) begin
			if (is_phase) begin
				if (!dir_down && count == top) begin
					next_dir_down = 1'b1;
					next_count    = (top == tmr_pkg::CNT_BOTTOM) ? count : count - 8'h01;
				end else if (dir_down && count == tmr_pkg::CNT_BOTTOM) begin
					next_dir_down = 1'b0;
					next_count    = count + 8'h01;
				end else begin
					next_count = dir_down ? count - 8'h01 : count + 8'h01;
				end
			end else begin
				next_dir_down = 1'b0;
				// only a real tick clears at top; forcing never does
				next_count    = (count == top) ? tmr_pkg::CNT_BOTTOM : count + 8'h01;
			end
		end

		next_ctrl_a  = ctrl_a;
		next_wm_bit2 = wm_bit2;
		next_clk_sel = clk_sel;
		next_cmp_a   = cmp_a;
		next_cmp_b   = cmp_b;
		next_mask    = mask;
		clr_f        = {ack_compare_b, ack_compare_a, ack_overflow};
		if (wr_en) begin
			unique case (aw_idx)
				tmr_pkg::IDX_CTRL_A: next_ctrl_a = w_byte;
				tmr_pkg::IDX_CTRL_B: begin
					next_wm_bit2 = w_byte[tmr_pkg::WM2_BIT];
					next_clk_sel = w_byte[2:0];
				end
				tmr_pkg::IDX_COUNT: begin
					next_count   = w_byte;
					next_blocked = 1'b1;
				end
				tmr_pkg::IDX_CMP_A: next_cmp_a = w_byte;
				tmr_pkg::IDX_CMP_B: next_cmp_b = w_byte;
				tmr_pkg::IDX_MASK:  next_mask = w_byte[2:0];
				tmr_pkg::IDX_FLAGS: clr_f = clr_f | w_byte[2:0];
				default: next_mask = mask;
			endcase
		end
		// set beats clear so no event is lost; forcing never sets a flag
		set_f      = {hit_b, hit_a, ovf_evt};
		next_flags = (flags & ~clr_f) | set_f;
		next_irq   = next_flags & mask & {3{global_irq_enable}};
		next_wave_a = wave_step(ctrl_a[tmr_pkg::OMA_LSB +: 2], wave_out_a, is_pwm,
			is_fast, hit_a || force_a, at_bot, dir_down, wm_bit2);
		next_wave_b = wave_step(ctrl_a[tmr_pkg::OMB_LSB +: 2], wave_out_b, is_pwm,
			is_fast, hit_b || force_b, at_bot, dir_down, 1'b0);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_a        <= tmr_pkg::RST_BYTE;
			wm_bit2       <= 1'b0;
			clk_sel       <= tmr_pkg::CS_STOP;
			count         <= tmr_pkg::RST_BYTE;
			cmp_a         <= tmr_pkg::RST_BYTE;
			cmp_b         <= tmr_pkg::RST_BYTE;
			mask          <= tmr_pkg::RST_FLAGS;
			flags         <= tmr_pkg::RST_FLAGS;
			pre           <= tmr_pkg::RST_PRE;
			dir_down      <= 1'b0;
			blocked       <= 1'b0;
			pin_s1        <= 1'b0;
			pin_s2        <= 1'b0;
			pin_prev      <= 1'b0;
			wave_out_a    <= 1'b0;
			wave_out_b    <= 1'b0;
			wave_oe_a     <= 1'b0;
			wave_oe_b     <= 1'b0;
			irq_overflow  <= 1'b0;
			irq_compare_a <= 1'b0;
			irq_compare_b <= 1'b0;
		end else begin
			ctrl_a        <= next_ctrl_a;
			wm_bit2       <= next_wm_bit2;
			clk_sel       <= next_clk_sel;
			count         <= next_count;
			cmp_a         <= next_cmp_a;
			cmp_b         <= next_cmp_b;
			mask          <= next_mask;
			flags         <= next_flags;
			pre           <= next_pre;
			dir_down      <= next_dir_down;
			blocked       <= next_blocked;
			// pin is sampled regardless of its direction
			pin_s1        <= ext_count_pin;
			pin_s2        <= pin_s1;
			pin_prev      <= pin_s2;
			wave_out_a    <= next_wave_a;
			wave_out_b    <= next_wave_b;
			wave_oe_a     <= next_ctrl_a[tmr_pkg::OMA_LSB +: 2] != 2'h0;
			wave_oe_b     <= next_ctrl_a[tmr_pkg::OMB_LSB +: 2] != 2'h0;
			irq_overflow  <= next_irq[tmr_pkg::FLG_OVF];
			irq_compare_a <= next_irq[tmr_pkg::FLG_CMPA];
			irq_compare_b <= next_irq[tmr_pkg::FLG_CMPB];
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic wr_ctrl_b;
	assign wr_ctrl_b = wr_en && aw_idx == tmr_pkg::IDX_CTRL_B;

	a_force_pwm_ignored: assert property (
		wr_ctrl_b && w_byte[tmr_pkg::FOC_A_BIT] && is_pwm && !tick |=> $stable(wave_out_a))
		else $error("force took effect in pwm mode");
	a_force_clear_out: assert property (
		wr_ctrl_b && w_byte[tmr_pkg::FOC_A_BIT] && !is_pwm &&
		ctrl_a[tmr_pkg::OMA_LSB +: 2] == 2'h2 && !(wr_en && aw_idx == tmr_pkg::IDX_CTRL_A)
		|=> !wave_out_a)
		else $error("forced clear did not clear output a");
	a_force_no_flag: assert property (
		wr_ctrl_b && !tick && clr_f == 3'h0 |=> flags == $past(flags) && $stable(count))
		else $error("force changed flags or counter");
	a_ctrlb_read_zero: assert property (
		do_read && s_axi_araddr[7:2] == tmr_pkg::IDX_CTRL_B |=> s_axi_rdata[7:4] == 4'h0)
		else $error("control b upper bits read nonzero");
	a_stop_holds: assert property (
		clk_sel == tmr_pkg::CS_STOP && !wr_en |=> $stable(count))
		else $error("stopped counter moved");
	a_ext_rise_counts: assert property (
		clk_sel == tmr_pkg::CS_EXT_RISE && pin_s2 && !pin_prev && wm == tmr_pkg::WM_NORMAL
		&& !wr_en |=> count == $past(count) + 8'h01)
		else $error("rising pin edge not counted");
	a_count_write: assert property (
		wr_en && aw_idx == tmr_pkg::IDX_COUNT |=> count == $past(w_byte) && blocked)
		else $error("counter write lost");
	a_write_blocks: assert property (
		tick && blocked && !flags[tmr_pkg::FLG_CMPA] |=> !flags[tmr_pkg::FLG_CMPA])
		else $error("match after counter write not blocked");
	a_irq_gate: assert property (
		irq_compare_a |-> $past(next_flags[tmr_pkg::FLG_CMPA] && mask[tmr_pkg::FLG_CMPA]
		&& global_irq_enable))
		else $error("compare a irq without cause");
	a_match_sets: assert property (
		tick && !blocked && count == cmp_b |=> flags[tmr_pkg::FLG_CMPB])
		else $error("compare b match did not set flag");
	a_ack_clears: assert property (
		ack_overflow && !ovf_evt |=> !flags[tmr_pkg::FLG_OVF])
		else $error("ack did not clear overflow flag");

	c_force_out: cover property (force_a ##1 wave_oe_a);
	c_ovf_irq: cover property (ovf_evt ##[1:4] irq_overflow);
	c_pc_turn: cover property (is_phase && tick && !dir_down ##1 dir_down);

endmodule // tmr_timer8

// *** tb.sv ***
module tb;
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	typedef struct {logic [31:0] lo; logic [31:0] hi; logic [1:0] resp;} tmr_note_s;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic        s_axi_awvalid = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_wvalid = 1'b0;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_bready = 1'b0;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic        s_axi_arvalid = 1'b0;
	logic [31:0] s_axi_rdata;
	logic        s_axi_rready = 1'b0;
	logic        ext_count_pin = 1'b0;
	logic        global_irq_enable = 1'b0;
	logic        ack_overflow = 1'b0;
	logic        ack_compare_a = 1'b0;
	logic        ack_compare_b = 1'b0;
	logic        irq_overflow, irq_compare_a, irq_compare_b;
	logic        wave_out_a, wave_out_b, wave_oe_a, wave_oe_b;
	tmr_note_s   rq[$];
	logic [1:0]  bq[$];
	int          error_cnt = 0;
	int          comparisons = 0;
	int          cycles = 0;
	int          divs[6] = '{0, 1, 8, 64, 256, 1024};
	logic [5:0]  reset_idx[6] = '{tmr_pkg::IDX_CTRL_A, tmr_pkg::IDX_COUNT, tmr_pkg::IDX_CTRL_B,
		tmr_pkg::IDX_CMP_A, tmr_pkg::IDX_FLAGS, tmr_pkg::IDX_MASK};
	logic [31:0] rv;

	tmr_timer8 dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .ext_count_pin(ext_count_pin),
		.global_irq_enable(global_irq_enable), .ack_overflow(ack_overflow),
		.ack_compare_a(ack_compare_a), .ack_compare_b(ack_compare_b),
		.irq_overflow(irq_overflow), .irq_compare_a(irq_compare_a),
		.irq_compare_b(irq_compare_b), .wave_out_a(wave_out_a), .wave_out_b(wave_out_b),
		.wave_oe_a(wave_oe_a), .wave_oe_b(wave_oe_b));

	// ------------------------------------------------------------
	// clock, timeout, checks
	// ------------------------------------------------------------
	initial begin
		forever #2 aclk = ~aclk;
	end

	task automatic final_report();
		$display("checks %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// ceiling well above the roughly 7000 cycles the sequence needs
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			error_cnt = error_cnt + 1;
			final_report();
		end
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons = comparisons + 1;
		if (seen !== exp) begin
			error_cnt = error_cnt + 1;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// monitor: each answer on the bus consumes the oldest note
	always @(posedge aclk) begin : mon
		tmr_note_s n;
		logic [1:0] br;
		if (s_axi_rvalid === 1'b1 && s_axi_rready) begin
			n = rq.pop_front();
			check("rresp", {30'h0, s_axi_rresp}, {30'h0, n.resp});
			if (n.lo == n.hi) begin
				check("rdata", s_axi_rdata, n.lo);
			end else begin
				check("rdata range", {31'h0, s_axi_rdata >= n.lo && s_axi_rdata <= n.hi}, 32'h1);
			end
		end
		if (s_axi_bvalid === 1'b1 && s_axi_bready) begin
			br = bq.pop_front();
			check("bresp", {30'h0, s_axi_bresp}, {30'h0, br});
		end
	end

	// ------------------------------------------------------------
	// bus tasks
	// ------------------------------------------------------------
	task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] resp);
		bq.push_back(resp);
		@(posedge aclk);
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_wdata <= {24'h00_0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [5:0] idx, input logic [31:0] lo, input logic [31:0] hi,
		input logic [1:0] resp);
		rq.push_back('{lo, hi, resp});
		@(posedge aclk);
		s_axi_araddr <= {idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
	endtask

	task automatic pins(input logic [2:0] irqs, input logic [1:0] waves);
		repeat (3) @(posedge aclk);
		check("irq", {29'h0, irq_compare_b, irq_compare_a, irq_overflow}, {29'h0, irqs});
		check("wave", {30'h0, wave_out_a, wave_out_b}, {30'h0, waves});
	endtask

	task automatic pulses(input logic [2:0] cs);
		wr(tmr_pkg::IDX_COUNT, 8'h00, tmr_pkg::RESP_OKAY);
		wr(tmr_pkg::IDX_CTRL_B, {5'h00, cs}, tmr_pkg::RESP_OKAY);
		repeat (5) begin
			@(posedge aclk) ext_count_pin <= 1'b1;
			repeat (8) @(posedge aclk);
			ext_count_pin <= 1'b0;
			repeat (8) @(posedge aclk);
		end
		wr(tmr_pkg::IDX_CTRL_B, 8'h00, tmr_pkg::RESP_OKAY);
		rd(tmr_pkg::IDX_COUNT, 32'h5, 32'h5, tmr_pkg::RESP_OKAY);
	endtask

	// ------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------
	initial begin
		rv = $urandom(32'hFC1B17CC);
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (reset_idx[i]) begin
			rd(reset_idx[i], 32'h0, 32'h0, tmr_pkg::RESP_OKAY);
		end
		rd(tmr_pkg::IDX_CMP_B, 32'h0, 32'h0, tmr_pkg::RESP_OKAY);
		rd(6'h00, 32'h0, 32'h0, tmr_pkg::RESP_SLVERR);
		wr(6'h01, 8'hFF, tmr_pkg::RESP_SLVERR);
		wr(tmr_pkg::IDX_MASK, 8'hFF, tmr_pkg::RESP_OKAY);
		rd(tmr_pkg::IDX_MASK, 32'h07, 32'h07, tmr_pkg::RESP_OKAY);
		wr(tmr_pkg::IDX_CTRL_B, 8'h38, tmr_pkg::RESP_OKAY);
		rd(tmr_pkg::IDX_CTRL_B, 32'h08, 32'h08, tmr_pkg::RESP_OKAY);
		rv = $urandom;
		wr(tmr_pkg::IDX_COUNT, rv[7:0], tmr_pkg::RESP_OKAY);
		wr(tmr_pkg::IDX_CMP_B, rv[15:8], tmr_pkg::RESP_OKAY);
		rd(tmr_pkg::IDX_COUNT, {24'h0, rv[7:0]}, {24'h0, rv[7:0]}, tmr_pkg::RESP_OKAY);
		rd(tmr_pkg::IDX_CMP_B, {24'h0, rv[15:8]}, {24'h0, rv[15:8]}, tmr_pkg::RESP_OKAY);
		// a write landing on a match value must not flag on the next tick
		wr(tmr_pkg::IDX_CMP_A, 8'h05, tmr_pkg::RESP_OKAY);
		wr(tmr_pkg::IDX_CMP_B, 8'h05, tmr_pkg::RESP_OKAY);
		wr(tmr_pkg::IDX_FLAGS, 8'h07, tmr_pkg::RESP_OKAY);
		wr(tmr_pkg::IDX_COUNT, 8'h05, tmr_pkg::RESP_OKAY);
		wr(tmr_pkg::IDX_CTRL_B, {5'h00, tmr_pkg::CS_DIV1}, tmr_pkg::RESP_OKAY);
		wr(tmr_pkg::IDX_CTRL_B, 8'h00, tmr_pkg::RESP_OKAY);
		rd(tmr_pkg::IDX_FLAGS, 32'h0, 32'h0, tmr_pkg::RESP_OKAY);
		// every prescaler tap, run for four of its periods
		for (int i = 0; i < 6; i++) begin
			wr(tmr_pkg::IDX_COUNT, 8'h00, tmr_pkg::RESP_OKAY);
			wr(tmr_pkg::IDX_CTRL_B, 8'(i), tmr_pkg::RESP_OKAY);
			repeat (4 * divs[i] + 8) @(posedge aclk);
			wr(tmr_pkg::IDX_CTRL_B, 8'h00, tmr_pkg::RESP_OKAY);
			if (i == 0) rd(tmr_pkg::IDX_COUNT, 32'h0, 32'h0, tmr_pkg::RESP_OKAY);
			else rd(tmr_pkg::IDX_COUNT, 32'd3, 32'(5 + 20 / divs[i]), tmr_pkg::RESP_OKAY);
		end
		pulses(tmr_pkg::CS_EXT_RISE);
		pulses(tmr_pkg::CS_EXT_FALL);
		// matches, overflow, masking, clearing
		wr(tmr_pkg::IDX_CMP_A, 8'd10, tmr_pkg::RESP_OKAY);
		wr(tmr_pkg::IDX_CMP_B, 8'd20, tmr_pkg::RESP_OKAY);
		wr(tmr_pkg::IDX_COUNT, 8'h00, tmr_pkg::RESP_OKAY);
		wr(tmr_pkg::IDX_FLAGS, 8'h07, tmr_pkg::RESP_OKAY);
		wr(tmr_pkg::IDX_MASK, 8'h05, tmr_pkg::RESP_OKAY);
		global_irq_enable <= 1'b1;
		wr(tmr_pkg::IDX_CTRL_B, {5'h00, tmr_pkg::CS_DIV1}, tmr_pkg::RESP_OKAY);
		repeat (300) @(posedge aclk);
		wr(tmr_pkg::IDX_CTRL_B, 8'h00, tmr_pkg::RESP_OKAY);
		rd(tmr_pkg::IDX_FLAGS, 32'h07, 32'h07, tmr_pkg::RESP_OKAY);
		pins(3'b101, 2'b00);
		global_irq_enable <= 1'b0;
		pins(3'b000, 2'b00);
		wr(tmr_pkg::IDX_FLAGS, 8'h02, tmr_pkg::RESP_OKAY);
		wr(tmr_pkg::IDX_FLAGS, 8'h00, tmr_pkg::RESP_OKAY);
		rd(tmr_pkg::IDX_FLAGS, 32'h05, 32'h05, tmr_pkg::RESP_OKAY);
		@(posedge aclk) ack_overflow <= 1'b1;
		@(posedge aclk) ack_overflow <= 1'b0;
		rd(tmr_pkg::IDX_FLAGS, 32'h04, 32'h04, tmr_pkg::RESP_OKAY);
		@(posedge aclk) ack_compare_b <= 1'b1;
		@(posedge aclk) ack_compare_b <= 1'b0;
		rd(tmr_pkg::IDX_FLAGS, 32'h00, 32'h00, tmr_pkg::RESP_OKAY);
		// forced compares through the toggle, clear and set output modes, then one in fast pwm
		wr(tmr_pkg::IDX_COUNT, 8'h55, tmr_pkg::RESP_OKAY);
		wr(tmr_pkg::IDX_CTRL_A, 8'h70, tmr_pkg::RESP_OKAY);
		wr(tmr_pkg::IDX_CTRL_B, 8'hC0, tmr_pkg::RESP_OKAY);
		pins(3'b000, 2'b11);
		check("oe", {30'h0, wave_oe_a, wave_oe_b}, 32'h3);
		wr(tmr_pkg::IDX_CTRL_A, 8'hA2, tmr_pkg::RESP_OKAY);
		wr(tmr_pkg::IDX_CTRL_B, 8'hC0, tmr_pkg::RESP_OKAY);
		pins(3'b000, 2'b00);
		wr(tmr_pkg::IDX_CTRL_A, 8'hD0, tmr_pkg::RESP_OKAY);
		wr(tmr_pkg::IDX_CTRL_B, 8'hC0, tmr_pkg::RESP_OKAY);
		pins(3'b000, 2'b11);
		rd(tmr_pkg::IDX_COUNT, 32'h55, 32'h55, tmr_pkg::RESP_OKAY);
		rd(tmr_pkg::IDX_FLAGS, 32'h00, 32'h00, tmr_pkg::RESP_OKAY);
		wr(tmr_pkg::IDX_CTRL_A, 8'h83, tmr_pkg::RESP_OKAY);
		wr(tmr_pkg::IDX_CTRL_B, 8'hC0, tmr_pkg::RESP_OKAY);
		pins(3'b000, 2'b11);
		check("oe", {30'h0, wave_oe_a, wave_oe_b}, 32'h2);
		rd(tmr_pkg::IDX_CTRL_B, 32'h00, 32'h00, tmr_pkg::RESP_OKAY);
		// phase correct: no overflow at the top turn, only back at bottom
		wr(tmr_pkg::IDX_COUNT, 8'h00, tmr_pkg::RESP_OKAY);
		wr(tmr_pkg::IDX_CTRL_A, 8'h01, tmr_pkg::RESP_OKAY);
		for (int k = 0; k < 2; k++) begin
			wr(tmr_pkg::IDX_CTRL_B, {5'h00, tmr_pkg::CS_DIV1}, tmr_pkg::RESP_OKAY);
			repeat (300) @(posedge aclk);
			wr(tmr_pkg::IDX_CTRL_B, 8'h00, tmr_pkg::RESP_OKAY);
			rv = 32'h06 + 32'(k);
			rd(tmr_pkg::IDX_FLAGS, rv, rv, tmr_pkg::RESP_OKAY);
		end
		repeat (4) @(posedge aclk);
		final_report();
	end
endmodule // tb
